/* src/dcl_pkg.sv */
package dcl_pkg;
  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] SYS_CFG_OFF = 8'h00;
  localparam logic [7:0] UNLOCK_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] PMD_BASE_OFF = 8'h10;
  localparam logic [7:0] CFG0_OFF = 8'h40;
  localparam logic [7:0] CFG3_OFF = 8'h44;
  localparam logic [7:0] SN_BASE_OFF = 8'h50;
  localparam logic [7:0] REMAP_OFF = 8'h60;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int LOCK_BIT = 12;
  localparam int DBG_EN_BIT = 3;
  localparam int ONE_WAY_BIT = 28;
  localparam int RSV_TOP_BIT = 31;
  localparam int DBG_FULL_BIT = 30;
  localparam int POSC_KICK_BIT = 21;
  localparam int POSC_GAIN_LO = 19;
  localparam int SOSC_KICK_BIT = 18;
  localparam int SOSC_GAIN_LO = 16;
  localparam int SOFT_CLR_BIT = 15;
  localparam int CFG_DBG_EN_BIT = 3;
  // -----------------------------------------------------------------
  // unlock keys and reset values
  // -----------------------------------------------------------------
  localparam logic [31:0] KEY_ONE = 32'haa996655;
  localparam logic [31:0] KEY_TWO = 32'h556699aa;
  localparam logic [31:0] RSV_ONES_MASK = 32'h3fc0_0000;
  localparam logic [31:0] SYS_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PMD_RST = 32'h0000_0000;
  localparam logic [31:0] REMAP_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_OPEN = 2'b10
  } dcl_unlock_e;
endpackage

/* src/dcl_top.sv */
// Operation
// - locked disable registers accept writes silently, contents unchanged
// - system config bit 12 locks disable registers when set
// - lock bit changes only after unlock sequence; otherwise refused
// - one-way option bit 28 of word three forbids clearing set lock
// - while locked under one-way, unlock sequence is ignored; while locked, pin remap writes rejected
// - under one-way, only device reset clears lock, re-enabling writes
// - word zero bit 31 copies signature word zero bit 31 at reset
// - word zero bit 30 selects full (1) or reduced (0) debug boot
// - bit 21 boosts primary oscillator kick start when set
// - bits 20-19 select primary oscillator gain level 0 to 3
// - bit 18 boosts secondary oscillator kick start when set
// - bits 17-16 select secondary oscillator gain level 0 to 3
// - bit 15: master clear pin gives system reset (1) or power-on (0)
// - word zero bit 3 sets debug port enable in system config
// - four read-only 32-bit unit serial number registers
// - serial numbers never altered by memory program or erase
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dcl_top #(
  parameter int PMD_COUNT = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [31:0] config_word_zero_i,
  input wire logic [31:0] config_word_three_i,
  input wire logic signature_bit_i,
  input wire logic [127:0] serial_bits_i,
  output logic debug_boot_full_o,
  output logic primary_osc_kick_o,
  output logic [1:0] primary_osc_gain_o,
  output logic secondary_osc_kick_o,
  output logic [1:0] secondary_osc_gain_o,
  output logic soft_clear_select_o,
  output logic debug_port_enable_o,
  output logic periph_disable_lock_o,
  output logic [PMD_COUNT*32-1:0] periph_disable_regs_o,
  output logic [31:0] pin_remap_o
);
  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic [31:0] cfg0_q;
  logic [31:0] cfg3_q;
  logic [127:0] sn_q;
  logic lock_q;
  logic dbg_en_q;
  logic open_w;
  logic lock_wr;
  logic unlock_wr;
  logic [31:0] pmd_q [PMD_COUNT];
  logic [31:0] remap_q;
  logic one_way;
  logic [31:0] rdata_d;
  logic err_d;

  // writes land only on the edge that completes the transfer, so each lands once
  assign wr_acc = psel_i & penable_i & pwrite_i & pready_o;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;
  assign lock_wr = wr_acc & (paddr_i == dcl_pkg::SYS_CFG_OFF);
  assign unlock_wr = wr_acc & (paddr_i == dcl_pkg::UNLOCK_OFF);
  assign one_way = cfg3_q[dcl_pkg::ONE_WAY_BIT];

  function automatic logic is_pmd(input logic [7:0] a);
    is_pmd = (a >= dcl_pkg::PMD_BASE_OFF) &&
             (a < dcl_pkg::PMD_BASE_OFF + 8'(4 * PMD_COUNT)) && (a[1:0] == 2'b00);
  endfunction

  function automatic int pmd_idx(input logic [7:0] a);
    pmd_idx = int'((a - dcl_pkg::PMD_BASE_OFF) >> 2);
  endfunction

  // -----------------------------------------------------------------
  // unlock sequence
  // -----------------------------------------------------------------
  // under one-way a set lock keeps the sequence shut until device reset
  dcl_unlock_seq u_unlock (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .key_we_i(unlock_wr),
    .key_i(pwdata_i),
    .consume_i(lock_wr),
    .block_i(one_way & lock_q),
    .open_o(open_w)
  );

  // -----------------------------------------------------------------
  // configuration latch
  // -----------------------------------------------------------------
  // words are captured while reset is held and frozen after release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg0_q <= config_word_zero_i | dcl_pkg::RSV_ONES_MASK;
      cfg0_q[dcl_pkg::RSV_TOP_BIT] <= signature_bit_i;
      cfg3_q <= config_word_three_i;
    end
  end

  // serial numbers have no write path at all
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sn_q <= serial_bits_i;
    end
  end

  // -----------------------------------------------------------------
  // lock and debug enable
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lock_q <= 1'b0;
    end else if (lock_wr && open_w) begin
      if (pwdata_i[dcl_pkg::LOCK_BIT]) begin
        lock_q <= 1'b1;
      end else if (!(one_way && lock_q)) begin
        lock_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dbg_en_q <= 1'b1;
    end else begin
      dbg_en_q <= cfg0_q[dcl_pkg::CFG_DBG_EN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // peripheral disable and pin remap registers
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PMD_COUNT; g++) begin : g_pmd
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pmd_q[g] <= dcl_pkg::PMD_RST;
        end else if (wr_acc && is_pmd(paddr_i) && pmd_idx(paddr_i) == g && !lock_q) begin
          pmd_q[g] <= pwdata_i;
        end
      end
      assign periph_disable_regs_o[g*32 +: 32] = pmd_q[g];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      remap_q <= dcl_pkg::REMAP_RST;
    end else if (wr_acc && paddr_i == dcl_pkg::REMAP_OFF && !lock_q) begin
      remap_q <= pwdata_i;
    end
  end

  // -----------------------------------------------------------------
  // read mux and response
  // -----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr_i == dcl_pkg::SYS_CFG_OFF) begin
      rdata_d[dcl_pkg::LOCK_BIT] = lock_q;
      rdata_d[dcl_pkg::DBG_EN_BIT] = dbg_en_q;
    end else if (paddr_i == dcl_pkg::UNLOCK_OFF) begin
      rdata_d = 32'h0000_0000;
    end else if (paddr_i == dcl_pkg::STATUS_OFF) begin
      rdata_d[0] = open_w;
      rdata_d[1] = lock_q;
    end else if (is_pmd(paddr_i)) begin
      rdata_d = pmd_q[pmd_idx(paddr_i)];
    end else if (paddr_i == dcl_pkg::CFG0_OFF) begin
      rdata_d = cfg0_q;
    end else if (paddr_i == dcl_pkg::CFG3_OFF) begin
      rdata_d = cfg3_q;
    end else if (paddr_i >= dcl_pkg::SN_BASE_OFF && paddr_i < dcl_pkg::SN_BASE_OFF + 8'h10
                 && paddr_i[1:0] == 2'b00) begin
      rdata_d = sn_q[32*int'(paddr_i[3:2]) +: 32];
      err_d = pwrite_i;
    end else if (paddr_i == dcl_pkg::REMAP_OFF) begin
      rdata_d = remap_q;
    end else begin
      err_d = 1'b1;
    end
  end

  // one wait state: answer registered in first access cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= err_d;
      prdata_o <= rd_acc ? rdata_d : 32'h0000_0000;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // control outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      debug_boot_full_o <= 1'b0;
      primary_osc_kick_o <= 1'b0;
      primary_osc_gain_o <= 2'b00;
      secondary_osc_kick_o <= 1'b0;
      secondary_osc_gain_o <= 2'b00;
      soft_clear_select_o <= 1'b0;
      debug_port_enable_o <= 1'b0;
      periph_disable_lock_o <= 1'b0;
      pin_remap_o <= dcl_pkg::REMAP_RST;
    end else begin
      debug_boot_full_o <= cfg0_q[dcl_pkg::DBG_FULL_BIT];
      primary_osc_kick_o <= cfg0_q[dcl_pkg::POSC_KICK_BIT];
      primary_osc_gain_o <= cfg0_q[dcl_pkg::POSC_GAIN_LO +: 2];
      secondary_osc_kick_o <= cfg0_q[dcl_pkg::SOSC_KICK_BIT];
      secondary_osc_gain_o <= cfg0_q[dcl_pkg::SOSC_GAIN_LO +: 2];
      soft_clear_select_o <= cfg0_q[dcl_pkg::SOFT_CLR_BIT];
      debug_port_enable_o <= dbg_en_q;
      periph_disable_lock_o <= lock_q;
      pin_remap_o <= remap_q;
    end
  end
endmodule
`default_nettype wire

/* src/dcl_unlock_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// two-key write sequence; window stays open until the next system config or unlock write
module dcl_unlock_seq (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic key_we_i,
  input wire logic [31:0] key_i,
  input wire logic consume_i,
  input wire logic block_i,
  output logic open_o
);
  dcl_pkg::dcl_unlock_e state_q;
  always_ff @(posedge clk_i) begin
    if (reset_i || block_i) begin
      state_q <= dcl_pkg::UL_IDLE;
    end else if (key_we_i) begin
      if (key_i == dcl_pkg::KEY_ONE) begin
        state_q <= dcl_pkg::UL_KEY1;
      end else if (key_i == dcl_pkg::KEY_TWO && state_q == dcl_pkg::UL_KEY1) begin
        state_q <= dcl_pkg::UL_OPEN;
      end else begin
        state_q <= dcl_pkg::UL_IDLE;
      end
    end else if (consume_i) begin
      state_q <= dcl_pkg::UL_IDLE;
    end
  end
  assign open_o = (state_q == dcl_pkg::UL_OPEN);
endmodule
`default_nettype wire

/* tb/dcl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dcl_props #(
  parameter int PMD_COUNT = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] config_word_zero_i,
  input wire logic [31:0] config_word_three_i,
  input wire logic [127:0] serial_bits_i,
  input wire logic debug_boot_full_o,
  input wire logic [1:0] primary_osc_gain_o,
  input wire logic debug_port_enable_o,
  input wire logic periph_disable_lock_o,
  input wire logic [PMD_COUNT*32-1:0] periph_disable_regs_o,
  input wire logic [31:0] pin_remap_o
);
  // -----------------------------------------------------------------
  // bus and configuration checks
  // -----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence first_acc;
    psel_i && $rose(penable_i);
  endsequence
  sequence wr_at_sn;
    first_acc ##0 (pwrite_i && paddr_i[7:4] == 4'h5);
  endsequence
  chk_ready_one_wait: assert property (first_acc |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after access");
  chk_serial_read: assert property (
    first_acc ##0 (!pwrite_i && paddr_i == dcl_pkg::SN_BASE_OFF) |=> prdata_o == serial_bits_i[31:0])
    else $error("serial read data wrong");
  chk_serial_refuse: assert property (wr_at_sn |=> pslverr_o)
    else $error("serial write not refused");
  // outputs of a fresh reset come from config seen while reset was high
  chk_cfg_latch: assert property ($fell(reset_i) ##1 1 |->
    {debug_boot_full_o, primary_osc_gain_o} == $past({config_word_zero_i[30], config_word_zero_i[20:19]}, 2))
    else $error("config fields not latched");
  chk_dbg_port: assert property ($fell(reset_i) ##2 1 |-> debug_port_enable_o == $past(config_word_zero_i[3], 3))
    else $error("debug port enable wrong");
  chk_cfg_hold: assert property (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3) |->
    $stable({debug_boot_full_o, primary_osc_gain_o, debug_port_enable_o}))
    else $error("config outputs moved");
  chk_locked_pmd: assert property ($changed(periph_disable_regs_o) |-> !$past(periph_disable_lock_o))
    else $error("disable regs changed while locked");
  chk_remap_lock: assert property ($changed(pin_remap_o) |-> !$past(periph_disable_lock_o))
    else $error("remap changed while locked");
  chk_lock_by_write: assert property ($changed(periph_disable_lock_o) |->
    $past(psel_i && penable_i && pwrite_i && pready_o && paddr_i == dcl_pkg::SYS_CFG_OFF, 2))
    else $error("lock moved without write");
  chk_pmd_write: assert property (
    psel_i && penable_i && pwrite_i && pready_o && paddr_i == dcl_pkg::PMD_BASE_OFF
      && !periph_disable_lock_o |=> periph_disable_regs_o[31:0] == $past(pwdata_i))
    else $error("disable reg write lost");
  chk_one_way: assert property ($fell(periph_disable_lock_o) |-> !config_word_three_i[28])
    else $error("lock cleared under one-way");
endmodule
bind dcl_top dcl_props #(.PMD_COUNT(PMD_COUNT)) dcl_props_i (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .config_word_zero_i(config_word_zero_i),
  .config_word_three_i(config_word_three_i),
  .serial_bits_i(serial_bits_i),
  .debug_boot_full_o(debug_boot_full_o),
  .primary_osc_gain_o(primary_osc_gain_o),
  .debug_port_enable_o(debug_port_enable_o),
  .periph_disable_lock_o(periph_disable_lock_o),
  .periph_disable_regs_o(periph_disable_regs_o),
  .pin_remap_o(pin_remap_o)
);
`default_nettype wire

/* tb/dcl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dcl_top_tb;
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i, signature_bit_i, pready_o, pslverr_o, err;
  logic debug_boot_full_o, primary_osc_kick_o, secondary_osc_kick_o, soft_clear_select_o;
  logic debug_port_enable_o, periph_disable_lock_o;
  logic [1:0] primary_osc_gain_o, secondary_osc_gain_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, config_word_zero_i, config_word_three_i, pin_remap_o, rd;
  logic [127:0] serial_bits_i;
  logic [63:0] periph_disable_regs_o;
  logic [8:0] fields;
  int bad_count, checks_done, cycles;
  assign fields = {debug_boot_full_o, primary_osc_kick_o, primary_osc_gain_o,
    secondary_osc_kick_o, secondary_osc_gain_o, soft_clear_select_o, debug_port_enable_o};
  dcl_top #(.PMD_COUNT(2)) dcl_top_i (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .config_word_zero_i(config_word_zero_i),
    .config_word_three_i(config_word_three_i),
    .signature_bit_i(signature_bit_i),
    .serial_bits_i(serial_bits_i),
    .debug_boot_full_o(debug_boot_full_o),
    .primary_osc_kick_o(primary_osc_kick_o),
    .primary_osc_gain_o(primary_osc_gain_o),
    .secondary_osc_kick_o(secondary_osc_kick_o),
    .secondary_osc_gain_o(secondary_osc_gain_o),
    .soft_clear_select_o(soft_clear_select_o),
    .debug_port_enable_o(debug_port_enable_o),
    .periph_disable_lock_o(periph_disable_lock_o),
    .periph_disable_regs_o(periph_disable_regs_o),
    .pin_remap_o(pin_remap_o)
  );
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    // registered outputs trail the completing edge by one cycle
    repeat (2) @(posedge clk_i);
  endtask
  task automatic do_reset;
    reset_i <= 1;
    repeat (4) @(posedge clk_i);
    reset_i <= 0;
  endtask
  task automatic unlock;
    apb(1, dcl_pkg::UNLOCK_OFF, dcl_pkg::KEY_ONE);
    apb(1, dcl_pkg::UNLOCK_OFF, dcl_pkg::KEY_TWO);
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_cfg(input logic [31:0] c, input logic s);
    config_word_zero_i <= c;
    signature_bit_i <= s;
    do_reset;
    apb(0, dcl_pkg::CFG0_OFF, 0);
    check(rd, {s, c[30], 8'hff, c[21:0]});
    apb(0, dcl_pkg::SYS_CFG_OFF, 0);
    check(32'(rd[3]), 32'(c[3]));
    // inputs moving after reset must not reach the outputs
    config_word_zero_i <= ~c;
    repeat (2) @(posedge clk_i);
    check(32'(fields), 32'({c[30], c[21:15], c[3]}));
  endtask
  task automatic t_lock(input logic ow);
    config_word_three_i <= {3'h0, ow, 28'h0};
    do_reset;
    apb(1, dcl_pkg::PMD_BASE_OFF, 32'ha5);
    check(periph_disable_regs_o[31:0], 32'ha5);
    apb(1, dcl_pkg::PMD_BASE_OFF + 8'h04, 32'h0f);
    check(periph_disable_regs_o[63:32], 32'h0f);
    apb(1, dcl_pkg::REMAP_OFF, 32'h33);
    apb(1, dcl_pkg::SYS_CFG_OFF, 32'h1000);
    check(32'(periph_disable_lock_o), 0);
    unlock;
    apb(1, dcl_pkg::SYS_CFG_OFF, 32'h1000);
    check(32'(periph_disable_lock_o), 1);
    apb(1, dcl_pkg::PMD_BASE_OFF, 32'h5a);
    check({31'h0, err}, 0);
    check(periph_disable_regs_o[31:0], 32'ha5);
    apb(1, dcl_pkg::REMAP_OFF, 32'hcc);
    check(pin_remap_o, 32'h33);
    unlock;
    if (ow) begin
      apb(0, dcl_pkg::STATUS_OFF, 0);
      check(32'(rd[0]), 0);
    end
    apb(1, dcl_pkg::SYS_CFG_OFF, 0);
    check(32'(periph_disable_lock_o), 32'(ow));
    if (ow) do_reset;
    apb(1, dcl_pkg::PMD_BASE_OFF, 32'h77);
    check(periph_disable_regs_o[31:0], 32'h77);
  endtask
  task automatic t_serial;
    for (int i = 0; i < 4; i++) begin
      apb(0, dcl_pkg::SN_BASE_OFF + 8'(4 * i), 0);
      check(rd, serial_bits_i[32*i +: 32]);
    end
    apb(1, dcl_pkg::SN_BASE_OFF, 32'hffff_ffff);
    check(32'(err), 1);
    apb(0, dcl_pkg::SN_BASE_OFF, 0);
    check(rd, serial_bits_i[31:0]);
    apb(0, 8'h30, 0);
    check({err, rd[30:0]}, 32'h8000_0000);
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, signature_bit_i} = '0;
    config_word_zero_i = 0;
    config_word_three_i = 0;
    serial_bits_i = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    t_cfg(32'h402a_8008, 1);
    t_cfg(32'hbfd5_7ff7, 0);
    t_lock(0);
    t_lock(1);
    t_serial;
    give_verdict;
  end
endmodule
`default_nettype wire
